// ===== hdl/bridge_memory_window_regs.svh
`ifndef BRIDGE_MEMORY_WINDOW_REGS_SVH
`define BRIDGE_MEMORY_WINDOW_REGS_SVH

// byte offsets inside the configuration header
`define OFS_MEMORY_WINDOW 12'h020
`define OFS_PREFETCH_WINDOW 12'h024
`define OFS_PREFETCH_BOTTOM_HIGH 12'h028
`define OFS_PREFETCH_TOP_HIGH 12'h02C
`define OFS_WINDOW_STATUS 12'h080

// number of words held in the register file, indexed by offset bits 3:2
`define REG_COUNT 4
`define REG_BLOCK_TAG 8'h02

// field positions shared by the two packed base/limit words
`define FLD_BOTTOM_LSB 4
`define FLD_BOTTOM_MSB 15
`define FLD_TOP_LSB 20
`define FLD_TOP_MSB 31

// writable bits, read-only constants and reset value of each word
`define MASK_MEMORY_WINDOW 32'hFFF0FFF0
`define MASK_PREFETCH_WINDOW 32'hFFF0FFF0
`define MASK_HIGH_WORD 32'hFFFFFFFF
`define RO_MEMORY_WINDOW 32'h00000000
`define RO_PREFETCH_WINDOW 32'h00010001
`define RO_HIGH_WORD 32'h00000000
`define RESET_WORD 32'h00000000

// implied low address bits of window bottom and top
`define BOTTOM_LOW_FILL 20'h00000
`define TOP_LOW_FILL 20'hFFFFF
`define HIGH_ZERO 32'h00000000

// hsize encodings accepted for lane selection
`define HSIZE_BYTE 3'h0
`define HSIZE_HALF 3'h1

`endif

// ===== hdl/bridge_memory_window_pkg.sv
package bridge_memory_window_pkg;

    typedef enum logic [1:0] {
        TRANS_IDLE,
        TRANS_BUSY,
        TRANS_NONSEQ,
        TRANS_SEQ
    } htrans_t;

    typedef enum {
        PHASE_IDLE,
        PHASE_WRITE,
        PHASE_READ_WAIT,
        PHASE_READ_DONE
    } bus_phase_t;

    typedef struct packed {
        logic [11:0] offset;
        logic write;
        logic [3:0] strobe;
    } bus_access_t;

    typedef struct packed {
        logic [63:0] bottom;
        logic [63:0] top;
    } window_t;

    typedef struct packed {
        logic valid;
        logic [63:0] addr;
    } txn_t;

    typedef struct packed {
        logic valid;
        logic memory_hit;
        logic prefetch_hit;
    } verdict_t;

endpackage

// ===== hdl/lane_merge.sv
module lane_merge
    import bridge_memory_window_pkg::*;
(
    input wire logic [31:0] old_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] strobe_i,
    input wire logic [31:0] writable_i,
    output logic [31:0] merged_o
);

    logic [31:0] lane_mask;

    // read-only and reserved bits keep their stored value whatever is written
    always_comb begin
        lane_mask = {{8{strobe_i[3]}}, {8{strobe_i[2]}}, {8{strobe_i[1]}}, {8{strobe_i[0]}}};
        merged_o = (old_i & ~(lane_mask & writable_i)) | (wdata_i & lane_mask & writable_i);
    end

endmodule

// ===== hdl/window_check.sv
module window_check
    import bridge_memory_window_pkg::*;
(
    input wire window_t window_i,
    input wire logic [63:0] addr_i,
    output logic enabled_o,
    output logic hit_o
);

    // inclusive on both ends; a bottom above the top leaves no address inside
    always_comb begin
        enabled_o = (window_i.bottom <= window_i.top);
        hit_o = (addr_i >= window_i.bottom) && (addr_i <= window_i.top);
    end

endmodule

// ===== hdl/bridge_memory_window_regs.sv
// Implementation choice: the AHB-Lite slave port.
`include "bridge_memory_window_regs.svh"

// Function
// - memory window top field holds bits 31:20, low bits ones, resets zero.
// - prefetch bottom and top low nibbles read 1h; writes ignored.
// - prefetch bottom field at bits 15:4 holds address 31:20, low zero.
// - prefetch top field at bits 31:20 holds address 31:20, low ones.
// - prefetch bottom upper half comes from its own upper register.
// - prefetch top upper half comes from its own upper register.
// - prefetch bottom upper register fully writable, resets to zero.
// - prefetch bottom and top decide forwarding of memory transactions.
// - memory window bottom field holds bits 31:20, low bits zero.
// - prefetch top upper register fully writable, resets to zero.
module bridge_memory_window_regs
    import bridge_memory_window_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire txn_t txn_i,
    output verdict_t verdict_o
);

    localparam logic [31:0] WRITABLE [`REG_COUNT] = '{
        `MASK_MEMORY_WINDOW,
        `MASK_PREFETCH_WINDOW,
        `MASK_HIGH_WORD,
        `MASK_HIGH_WORD
    };

    localparam logic [31:0] READ_ONLY [`REG_COUNT] = '{
        `RO_MEMORY_WINDOW,
        `RO_PREFETCH_WINDOW,
        `RO_HIGH_WORD,
        `RO_HIGH_WORD
    };

    // byte lanes touched by a transfer; wider sizes fall back to the whole word
    function automatic logic [3:0] lane_strobe(input logic [2:0] size, input logic [1:0] low);
        logic [3:0] strobe;
        strobe = 4'hF;
        if (size == `HSIZE_BYTE) begin
            strobe = 4'h1 << low;
        end else if (size == `HSIZE_HALF) begin
            strobe = low[1] ? 4'hC : 4'h3;
        end
        return strobe;
    endfunction

    function automatic logic block_mapped(input logic [11:0] offset);
        return offset[11:4] == `REG_BLOCK_TAG;
    endfunction

    // bus phase state
    bus_phase_t phase_reg;
    bus_phase_t phase_next;
    bus_access_t access_reg;
    bus_access_t access_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic hreadyout_reg;
    logic hreadyout_next;
    logic hresp_reg;
    logic hresp_next;

    // register file state
    logic [31:0] word_reg [`REG_COUNT];
    logic [31:0] word_next [`REG_COUNT];
    logic [31:0] merged [`REG_COUNT];
    logic [`REG_COUNT-1:0] write_hit;

    // decode state
    verdict_t verdict_reg;
    verdict_t verdict_next;

    window_t memory_window;
    window_t prefetch_window;
    logic memory_enabled;
    logic prefetch_enabled;
    logic memory_hit;
    logic prefetch_hit;

    // named views of the stored fields
    logic [11:0] memory_window_bottom;
    logic [11:0] memory_window_top;
    logic [11:0] prefetch_window_bottom;
    logic [11:0] prefetch_window_top;
    logic [31:0] prefetch_window_bottom_high;
    logic [31:0] prefetch_window_top_high;

    logic accept;
    logic [1:0] word_index;
    logic [31:0] read_value;
    logic [31:0] status_word;

    assign accept = hsel_i && hready_i && htrans_i[1];
    assign word_index = access_reg.offset[3:2];

    // bus phase sequencing
    // reads take one wait state so a read right behind a write sees the new value
    always_comb begin
        phase_next = phase_reg;
        access_next = access_reg;
        hresp_next = 1'b0;
        unique case (phase_reg)
            PHASE_IDLE, PHASE_WRITE, PHASE_READ_DONE: begin
                if (accept) begin
                    access_next.offset = haddr_i[11:0];
                    access_next.write = hwrite_i;
                    access_next.strobe = lane_strobe(hsize_i, haddr_i[1:0]);
                    phase_next = hwrite_i ? PHASE_WRITE : PHASE_READ_WAIT;
                end else begin
                    phase_next = PHASE_IDLE;
                end
            end
            PHASE_READ_WAIT: begin
                phase_next = PHASE_READ_DONE;
            end
        endcase
        hreadyout_next = (phase_next != PHASE_READ_WAIT);
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= PHASE_IDLE;
            access_reg <= '0;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else if (ce_i) begin
            phase_reg <= phase_next;
            access_reg <= access_next;
            hreadyout_reg <= hreadyout_next;
            hresp_reg <= hresp_next;
        end
    end

    // read data is built during the wait state and held until the next read
    always_comb begin
        read_value = 32'h00000000;
        if (block_mapped(access_reg.offset)) begin
            read_value = (word_reg[word_index] & WRITABLE[word_index])
                | READ_ONLY[word_index];
        end else if (access_reg.offset == `OFS_WINDOW_STATUS) begin
            read_value = status_word;
        end
        hrdata_next = hrdata_reg;
        if (phase_reg == PHASE_READ_WAIT) begin
            hrdata_next = read_value;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_reg <= 32'h00000000;
        end else if (ce_i) begin
            hrdata_reg <= hrdata_next;
        end
    end

    assign status_word = {30'h00000000, prefetch_enabled, memory_enabled};

    // per-word write merge; only writable bits take bus data
    generate
        for (genvar i = 0; i < `REG_COUNT; i++) begin : g_word
            assign write_hit[i] = (phase_reg == PHASE_WRITE)
                && access_reg.write
                && block_mapped(access_reg.offset)
                && (word_index == 2'(i));

            lane_merge u_merge (
                .old_i(word_reg[i]),
                .wdata_i(hwdata_i),
                .strobe_i(access_reg.strobe),
                .writable_i(WRITABLE[i]),
                .merged_o(merged[i])
            );

            always_comb begin
                word_next[i] = write_hit[i] ? merged[i] : word_reg[i];
            end

            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    word_reg[i] <= `RESET_WORD;
                end else if (ce_i) begin
                    word_reg[i] <= word_next[i];
                end
            end
        end
    endgenerate

    // the decode reads these names, so a change of word layout stays in one place
    assign memory_window_bottom = word_reg[0][`FLD_BOTTOM_MSB:`FLD_BOTTOM_LSB];
    assign memory_window_top = word_reg[0][`FLD_TOP_MSB:`FLD_TOP_LSB];
    assign prefetch_window_bottom = word_reg[1][`FLD_BOTTOM_MSB:`FLD_BOTTOM_LSB];
    assign prefetch_window_top = word_reg[1][`FLD_TOP_MSB:`FLD_TOP_LSB];
    assign prefetch_window_bottom_high = word_reg[2];
    assign prefetch_window_top_high = word_reg[3];

    // expand the stored fields into full 64-bit window bounds
    // the ordinary memory window sits below 4G, so its upper half is zero
    always_comb begin
        memory_window.bottom = {`HIGH_ZERO, memory_window_bottom, `BOTTOM_LOW_FILL};
        memory_window.top = {`HIGH_ZERO, memory_window_top, `TOP_LOW_FILL};
        prefetch_window.bottom = {prefetch_window_bottom_high, prefetch_window_bottom,
            `BOTTOM_LOW_FILL};
        prefetch_window.top = {prefetch_window_top_high, prefetch_window_top,
            `TOP_LOW_FILL};
    end

    window_check u_memory_check (
        .window_i(memory_window),
        .addr_i(txn_i.addr),
        .enabled_o(memory_enabled),
        .hit_o(memory_hit)
    );

    window_check u_prefetch_check (
        .window_i(prefetch_window),
        .addr_i(txn_i.addr),
        .enabled_o(prefetch_enabled),
        .hit_o(prefetch_hit)
    );

    // one-cycle decode verdict for each transaction presented
    always_comb begin
        verdict_next.valid = txn_i.valid;
        verdict_next.memory_hit = txn_i.valid && memory_hit;
        verdict_next.prefetch_hit = txn_i.valid && prefetch_hit;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            verdict_reg <= '0;
        end else if (ce_i) begin
            verdict_reg <= verdict_next;
        end
    end

    assign hrdata_o = hrdata_reg;
    assign hreadyout_o = hreadyout_reg;
    assign hresp_o = hresp_reg;
    assign verdict_o = verdict_reg;

endmodule

// ===== verification/bridge_memory_window_assertions.sv
module bridge_memory_window_checker
    import bridge_memory_window_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire txn_t txn_i,
    input wire verdict_t verdict_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic take;
    assign take = hsel_i && hready_i && htrans_i[1] && ce_i;
    a_read_one_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (take && hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    a_nibble_ro: assert property (take && !hwrite_i && haddr_i[11:0] == 12'h024
        |=> ##1 hrdata_o[3:0] == 4'h1 && hrdata_o[19:16] == 4'h1)
        else $error("capability nibble wrong");
    a_reserved_zero: assert property (take && !hwrite_i && haddr_i[11:0] == 12'h020
        |=> ##1 hrdata_o[19:16] == 4'h0 && hrdata_o[3:0] == 4'h0)
        else $error("reserved bits not zero");
    a_idle_verdict: assert property (ce_i && !txn_i.valid |=> verdict_o == '0)
        else $error("verdict without transaction");
    a_verdict_valid: assert property (ce_i && txn_i.valid |=> verdict_o.valid)
        else $error("verdict missing");
    a_high_mem_miss: assert property (ce_i && txn_i.valid && txn_i.addr[63:32] != 32'h0
        |=> !verdict_o.memory_hit)
        else $error("memory window hit above 4G");
    a_freeze_hold: assert property (!ce_i |=> $stable(verdict_o) && $stable(hrdata_o))
        else $error("state moved while frozen");
endmodule

bind bridge_memory_window_regs bridge_memory_window_checker i_bridge_memory_window_checker (
    .clock_i, .rst_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .txn_i, .verdict_o);

// ===== verification/tb_top.sv
module tb_top
    import bridge_memory_window_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, rst_i, ce_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    txn_t txn_i;
    verdict_t verdict_o;
    int error_cnt, samples_checked;

    bridge_memory_window_regs i_bridge_memory_window_regs (
        .clock_i, .rst_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
        .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .txn_i, .verdict_o);

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic conclude();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // values are taken just before the edge, which is what that edge samples
    task automatic wait_ready(output logic [31:0] rd);
        int n;
        logic r;
        logic s;
        n = 0;
        do begin
            @(negedge clock_i);
            r = hreadyout_o;
            rd = hrdata_o;
            s = hresp_o;
            @(posedge clock_i);
            n++;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) begin
            error_cnt++;
            conclude();
        end else begin
            check("hresp", 64'h0, {63'h0, s});
        end
    endtask

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        wait_ready(rd);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        wait_ready(rd);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic [31:0] d;
        bus(a, 1'b1, v, d);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(a, 1'b0, 32'h0, d);
        check($sformatf("read %h", a), {32'h0, exp}, {32'h0, d});
    endtask

    // exp is {memory_hit, prefetch_hit}
    task automatic decode(input logic [63:0] a, input logic [1:0] exp);
        txn_i <= '{valid: 1'b1, addr: a};
        @(posedge clock_i);
        txn_i <= '0;
        @(negedge clock_i);
        check($sformatf("decode %h", a), {61'h0, 1'b1, exp}, {61'h0, verdict_o});
        @(posedge clock_i);
    endtask

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = 32'h0;
        txn_i = '0;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rd_chk(32'h20, 32'h00000000);
        rd_chk(32'h24, 32'h00010001);
        rd_chk(32'h28, 32'h00000000);
        rd_chk(32'h2C, 32'h00000000);
        rd_chk(32'h80, 32'h00000003);
        decode(64'h0, 2'h3);
        wr(32'h20, 32'hFFFFFFFF);
        rd_chk(32'h20, 32'hFFF0FFF0);
        wr(32'h24, 32'hFFFFFFFF);
        rd_chk(32'h24, 32'hFFF1FFF1);
        wr(32'h24, 32'h00000000);
        rd_chk(32'h24, 32'h00010001);
        wr(32'h28, 32'hA5A5A5A5);
        rd_chk(32'h28, 32'hA5A5A5A5);
        wr(32'h2C, 32'h5A5A5A5A);
        rd_chk(32'h2C, 32'h5A5A5A5A);
        wr(32'h30, 32'hFFFFFFFF);
        rd_chk(32'h30, 32'h00000000);
        wr(32'h20, 32'h1FF01000);
        wr(32'h24, 32'h2FF02000);
        wr(32'h28, 32'h00000001);
        wr(32'h2C, 32'h00000002);
        decode(64'h0FFF_FFFF, 2'h0);
        decode(64'h1000_0000, 2'h2);
        decode(64'h1FFF_FFFF, 2'h2);
        decode(64'h2000_0000, 2'h0);
        decode(64'h1_1000_0000, 2'h0);
        decode(64'h1_1FFF_FFFF, 2'h0);
        decode(64'h1_2000_0000, 2'h1);
        decode(64'h2_2FFF_FFFF, 2'h1);
        decode(64'h2_3000_0000, 2'h0);
        ce_i <= 1'b0;
        wr(32'h28, 32'h0000FFFF);
        ce_i <= 1'b1;
        rd_chk(32'h28, 32'h00000001);
        hsize_i <= 3'h0;
        wr(32'h2A, 32'h00CC0000);
        hsize_i <= 3'h1;
        wr(32'h2E, 32'hBEEF0000);
        hsize_i <= 3'h2;
        rd_chk(32'h28, 32'h00CC0001);
        rd_chk(32'h2C, 32'hBEEF0002);
        wr(32'h20, 32'h00000010);
        decode(64'h0, 2'h0);
        rd_chk(32'h80, 32'h00000002);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rd_chk(32'h20, 32'h00000000);
        rd_chk(32'h28, 32'h00000000);
        rd_chk(32'h2C, 32'h00000000);
        rd_chk(32'h80, 32'h00000003);
        conclude();
    end
endmodule
